// ===== core/adcc_control.sv
// Contract
// - twelve-bit results, eight selectable inputs
// - timed from internal system clock only
// - result valid within three milliseconds
// - each trigger starts fresh conversion
// - control register readable, writable, holds fields
// - result registers read only
// - upper eight bits in one read
// - format bit drops MSB, shifts left
// - idle converter enters power save itself
// - select code 0011 measures battery pin
// - temperature code maps linearly
// - sense full-scale chosen in config register
`timescale 1ns/1ps
`include "adcc_defs.svh"

module adcc_control #(
  parameter int unsigned DEADLINE_CYCLES = `ADCC_CONV_TIME_NS / `ADCC_CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // converter core
  output logic o_core_power,
  output logic o_core_start,
  output logic [2:0] o_core_select,
  output logic [7:0] o_sense_scale,
  input wire logic i_core_done,
  input wire logic [11:0] i_core_data,
  // status
  output logic o_busy
);

  // ==========================================================
  // state
  adcc_pkg::adcc_state_t state_ff;
  adcc_pkg::adcc_state_t nxt_state;
  logic [3:0] sel_ff;
  logic [3:0] nxt_sel;
  logic fmt_ff;
  logic nxt_fmt;
  logic act_fmt_ff;
  logic nxt_act_fmt;
  logic [7:0] sense_ff;
  logic [7:0] nxt_sense;
  logic [7:0] res_hi_ff;
  logic [7:0] nxt_res_hi;
  logic [7:0] res_lo_ff;
  logic [7:0] nxt_res_lo;
  logic start_ff;
  logic nxt_start;
  logic power_ff;
  logic nxt_power;
  logic [2:0] core_sel_ff;
  logic [2:0] nxt_core_sel;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;
  logic wr_ctrl;
  logic trigger;
  logic expired;
  logic finish;
  adcc_pkg::adcc_sample_t formatted;

  assign wr_ctrl = i_reg_wr && (i_reg_addr == `ADCC_CTRL_ADDR);
  assign trigger = wr_ctrl && i_reg_wdata[`ADCC_TRIG_BIT];

  // ==========================================================
  // deadline timer
  adcc_deadline #(
    .CYCLES(DEADLINE_CYCLES)
  ) u_deadline (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_restart(trigger),
    .i_run(state_ff == adcc_pkg::ST_CONVERT),
    .o_expired(expired)
  );

  // core done from an aborted run is ignored while a new start is out
  assign finish = (state_ff == adcc_pkg::ST_CONVERT) && !start_ff && (i_core_done || expired);

  // ==========================================================
  // result formatting
  always_comb begin
    if (act_fmt_ff) begin
      formatted = {i_core_data[10:0], 1'b0};
    end else begin
      formatted = i_core_data;
    end
  end

  // ==========================================================
  // control and conversion sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_sel = sel_ff;
    nxt_fmt = fmt_ff;
    nxt_act_fmt = act_fmt_ff;
    nxt_sense = sense_ff;
    nxt_res_hi = res_hi_ff;
    nxt_res_lo = res_lo_ff;
    nxt_start = 1'b0;
    nxt_core_sel = core_sel_ff;
    if (i_reg_wr && (i_reg_addr == `ADCC_SENSE_ADDR)) begin
      nxt_sense = i_reg_wdata;
    end
    if (wr_ctrl) begin
      nxt_sel = i_reg_wdata[`ADCC_SEL_MSB:`ADCC_SEL_LSB];
      nxt_fmt = i_reg_wdata[`ADCC_FMT_BIT];
    end
    if (trigger) begin
      nxt_state = adcc_pkg::ST_CONVERT;
      nxt_start = 1'b1;
      nxt_act_fmt = i_reg_wdata[`ADCC_FMT_BIT];
      nxt_core_sel = i_reg_wdata[2:0];
    end else begin
      case (state_ff)
        adcc_pkg::ST_IDLE: begin
          nxt_state = adcc_pkg::ST_IDLE;
        end
        adcc_pkg::ST_CONVERT: begin
          if (finish) begin
            nxt_state = adcc_pkg::ST_IDLE;
            nxt_res_hi = formatted[11:4];
            nxt_res_lo = {4'h0, formatted[3:0]};
          end
        end
        default: begin
          nxt_state = adcc_pkg::ST_IDLE;
        end
      endcase
    end
    nxt_power = (nxt_state != adcc_pkg::ST_IDLE);
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_ff <= adcc_pkg::ST_IDLE;
      sel_ff <= 4'h0;
      fmt_ff <= 1'b0;
      act_fmt_ff <= 1'b0;
      sense_ff <= `ADCC_SENSE_RST;
      res_hi_ff <= `ADCC_RES_RST;
      res_lo_ff <= `ADCC_RES_RST;
      start_ff <= 1'b0;
      power_ff <= 1'b0;
      core_sel_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      sel_ff <= nxt_sel;
      fmt_ff <= nxt_fmt;
      act_fmt_ff <= nxt_act_fmt;
      sense_ff <= nxt_sense;
      res_hi_ff <= nxt_res_hi;
      res_lo_ff <= nxt_res_lo;
      start_ff <= nxt_start;
      power_ff <= nxt_power;
      core_sel_ff <= nxt_core_sel;
    end
  end

  // ==========================================================
  // register read
  always_comb begin
    nxt_rvalid = i_reg_rd;
    nxt_rdata = 8'h00;
    if (i_reg_rd) begin
      case (i_reg_addr)
        `ADCC_CTRL_ADDR: begin
          nxt_rdata = {(state_ff == adcc_pkg::ST_CONVERT), fmt_ff, 2'b00, sel_ff};
        end
        `ADCC_RES_HI_ADDR: begin
          nxt_rdata = res_hi_ff;
        end
        `ADCC_RES_LO_ADDR: begin
          nxt_rdata = res_lo_ff;
        end
        `ADCC_SENSE_ADDR: begin
          nxt_rdata = sense_ff;
        end
        default: begin
          nxt_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // ==========================================================
  // outputs
  assign o_reg_rdata = rdata_ff;
  assign o_reg_rvalid = rvalid_ff;
  assign o_core_power = power_ff;
  assign o_core_start = start_ff;
  assign o_core_select = core_sel_ff;
  assign o_sense_scale = sense_ff;
  assign o_busy = power_ff;

  // ==========================================================
  // checks
  int unsigned busy_cnt_ff;
  int unsigned nxt_busy_cnt;

  always_comb begin
    nxt_busy_cnt = busy_cnt_ff + 1;
    if (trigger || state_ff == adcc_pkg::ST_IDLE) begin
      nxt_busy_cnt = 0;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      busy_cnt_ff <= 0;
    end else begin
      busy_cnt_ff <= nxt_busy_cnt;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  sequence trig_s;
    trigger;
  endsequence

  sequence launch_s;
    o_core_start && o_core_power;
  endsequence

  fresh_start_a: assert property (trig_s |=> launch_s ##1 !o_core_start)
    else $error("trigger did not launch one start pulse");

  deadline_bound_a: assert property (busy_cnt_ff <= DEADLINE_CYCLES)
    else $error("conversion outlived the deadline");

  power_save_a: assert property ((state_ff == adcc_pkg::ST_IDLE && !trigger) |=> !o_core_power)
    else $error("converter powered while idle");

  result_hold_a: assert property (!finish |=> ($stable(res_hi_ff) && $stable(res_lo_ff)))
    else $error("result changed without a completed conversion");

  fmt_shift_a: assert property ((finish && act_fmt_ff) |=> res_hi_ff == $past(i_core_data[10:3]))
    else $error("shifted format wrong");

  upper_bits_a: assert property ((finish && !act_fmt_ff) |=>
      (res_hi_ff == $past(i_core_data[11:4]) && res_lo_ff == {4'h0, $past(i_core_data[3:0])}))
    else $error("plain format wrong");

  ctrl_readback_a: assert property ((wr_ctrl && !trigger) ##1 (i_reg_rd && i_reg_addr == `ADCC_CTRL_ADDR)
      |=> o_reg_rdata[6:0] == {$past(i_reg_wdata[6], 2), 2'b00, $past(i_reg_wdata[3:0], 2)})
    else $error("control readback mismatch");

  select_route_a: assert property (o_core_start |-> o_core_select == sel_ff[2:0])
    else $error("selected input not routed");

  sense_cfg_a: assert property ((i_reg_wr && i_reg_addr == `ADCC_SENSE_ADDR) |=>
      o_sense_scale == $past(i_reg_wdata))
    else $error("sense scale not applied");

  read_valid_a: assert property (i_reg_rd |=> o_reg_rvalid ##1 (o_reg_rvalid == $past(i_reg_rd)))
    else $error("read answer timing wrong");

  sequence done_seen_s;
    (state_ff == adcc_pkg::ST_CONVERT) && !start_ff && i_core_done && !trigger;
  endsequence

  sequence settled_s;
    !o_busy && !o_core_power;
  endsequence

  done_latch_a: assert property (done_seen_s |=> settled_s)
    else $error("core done did not end the conversion");

  deadline_end_a: assert property (((state_ff == adcc_pkg::ST_CONVERT) && !start_ff && expired && !trigger)
      |=> settled_s)
    else $error("deadline did not end the conversion");

  abort_restart_a: assert property ((trigger && state_ff == adcc_pkg::ST_CONVERT) |=> (o_busy && o_core_start))
    else $error("retrigger did not restart the conversion");

  busy_readback_a: assert property ((i_reg_rd && i_reg_addr == `ADCC_CTRL_ADDR) |=>
      o_reg_rdata[7] == $past(state_ff == adcc_pkg::ST_CONVERT))
    else $error("busy bit readback wrong");

  ro_write_a: assert property ((i_reg_wr && !finish && (i_reg_addr == `ADCC_RES_HI_ADDR ||
      i_reg_addr == `ADCC_RES_LO_ADDR)) |=> ($stable(res_hi_ff) && $stable(res_lo_ff)))
    else $error("result register took a write");

endmodule : adcc_control

// ===== core/adcc_defs.svh
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH

// ==========================================================
// register offsets
`define ADCC_SENSE_ADDR 8'h19
`define ADCC_CTRL_ADDR 8'h87
`define ADCC_RES_HI_ADDR 8'h88
`define ADCC_RES_LO_ADDR 8'h89

// ==========================================================
// control register fields
`define ADCC_TRIG_BIT 7
`define ADCC_FMT_BIT 6
`define ADCC_SEL_MSB 3
`define ADCC_SEL_LSB 0
`define ADCC_SEL_BATTERY 4'h3
`define ADCC_NUM_INPUTS 8
`define ADCC_RES_BITS 12

// ==========================================================
// reset values
`define ADCC_CTRL_RST 8'h00
`define ADCC_SENSE_RST 8'h00
`define ADCC_RES_RST 8'h00

// ==========================================================
// timing
`define ADCC_CONV_TIME_NS 3000000
`define ADCC_CLK_PERIOD_NS 5
`define ADCC_CONV_MARGIN 3

`endif

// ===== core/adcc_pkg.sv
package adcc_pkg;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_CONVERT
  } adcc_state_t;

  typedef logic [11:0] adcc_sample_t;

endpackage : adcc_pkg

// ===== core/adcc_deadline.sv
`timescale 1ns/1ps
`include "adcc_defs.svh"

module adcc_deadline #(
  parameter int unsigned CYCLES = 600000
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // control
  input wire logic i_restart,
  input wire logic i_run,
  // status
  output logic o_expired
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - `ADCC_CONV_MARGIN);

  logic [CW-1:0] count_ff;
  logic [CW-1:0] nxt_count;
  logic expired_ff;
  logic nxt_expired;

  // ==========================================================
  // deadline counter
  always_comb begin
    nxt_count = count_ff;
    nxt_expired = 1'b0;
    if (i_restart) begin
      nxt_count = '0;
    end else if (i_run) begin
      if (count_ff < LAST) begin
        nxt_count = count_ff + CW'(1);
      end
      nxt_expired = (count_ff >= LAST);
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count_ff <= '0;
      expired_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      expired_ff <= nxt_expired;
    end
  end

  assign o_expired = expired_ff;

endmodule : adcc_deadline

// ===== bench/adcc_core_model.sv
`timescale 1ns/1ps

module adcc_core_model #(
  parameter int LAT = 6
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // control from block, mute from bench
  input wire logic i_power,
  input wire logic i_start,
  input wire logic [2:0] i_select,
  input wire logic i_mute,
  // result to block
  output logic o_done,
  output logic [11:0] o_data
);
  int cnt_ff;
  logic [11:0] code;
  // ==========================================================
  // per-input twelve-bit code
  assign code = {i_select, 9'h15A};
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) cnt_ff <= 0;
    else if (i_start) cnt_ff <= LAT;
    else if (cnt_ff > 0 && i_power) cnt_ff <= cnt_ff - 1;
  end
  // mute keeps the core silent; idle data is the inverse code
  assign o_done = (cnt_ff == 1) && !i_mute;
  assign o_data = o_done ? code : ~code;
endmodule : adcc_core_model

// ===== bench/adcc_tb_top.sv
`timescale 1ns/1ps

module tb_top;
  localparam int DL = 40;
  localparam int LAT = 6;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [7:0] i_reg_addr = 8'h00;
  logic i_reg_wr = 1'b0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_reg_rd = 1'b0;
  logic mute = 1'b0;
  logic [7:0] o_reg_rdata;
  logic o_reg_rvalid, o_core_power, o_core_start, o_busy, core_done;
  logic [2:0] o_core_select;
  logic [7:0] o_sense_scale;
  logic [11:0] core_data;
  int n_errors = 0;
  int samples_checked = 0;

  always #2.5 i_clock = ~i_clock;

  adcc_control #(.DEADLINE_CYCLES(DL)) DUT (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_core_power(o_core_power),
    .o_core_start(o_core_start), .o_core_select(o_core_select), .o_sense_scale(o_sense_scale),
    .i_core_done(core_done), .i_core_data(core_data), .o_busy(o_busy));

  adcc_core_model #(.LAT(LAT)) core (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_power(o_core_power),
    .i_start(o_core_start), .i_select(o_core_select), .i_mute(mute), .o_done(core_done), .o_data(core_data));

  task conclude;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clock);
    i_reg_wr <= 1'b0;
    #1;
  endtask : reg_wr

  task reg_rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clock);
    i_reg_rd <= 1'b0;
    #1;
    chk({7'h00, o_reg_rvalid}, 8'h01, "rvalid");
    chk(o_reg_rdata, exp, what);
  endtask : reg_rd

  // trigger one conversion and judge timing, power save and both bytes
  task convert(input logic [2:0] sel, input logic f, input logic m);
    logic [11:0] c;
    int n;
    c = {sel, 9'h15A};
    if (m) c = ~c;
    if (f) c = {c[10:0], 1'b0};
    @(posedge i_clock);
    mute <= m;
    reg_wr(8'h87, {1'b1, f, 3'b000, sel});
    chk({7'h00, o_core_start}, 8'h01, "start");
    chk({o_busy, o_core_power, 3'b000, o_core_select}, {5'b11000, sel}, "busy");
    n = 0;
    while (o_busy === 1'b1) begin
      @(posedge i_clock);
      #1;
      n++;
      if (n > 200) begin
        n_errors++;
        $display("unexpected at %0t: conversion hangs", $time);
        conclude();
      end
    end
    chk({7'h00, n <= (m ? DL : LAT + 4)}, 8'h01, "latency");
    chk({7'h00, o_core_power}, 8'h00, "power");
    reg_rd(8'h88, c[11:4], "high");
    reg_rd(8'h89, {4'h0, c[3:0]}, "low");
    mute <= 1'b0;
  endtask : convert

  task t_reset_values;
    reg_rd(8'h87, 8'h00, "ctrl");
    reg_rd(8'h88, 8'h00, "high");
    reg_rd(8'h89, 8'h00, "low");
    reg_rd(8'h19, 8'h00, "sense");
  endtask : t_reset_values

  task t_ctrl_rw;
    reg_wr(8'h87, 8'h4B);
    reg_rd(8'h87, 8'h4B, "ctrl");
    reg_wr(8'h87, 8'h3F);
    reg_rd(8'h87, 8'h0F, "ctrl");
    @(posedge i_clock);
    i_reg_addr <= 8'h87;
    i_reg_wdata <= 8'h45;
    i_reg_wr <= 1'b1;
    @(posedge i_clock);
    i_reg_wr <= 1'b0;
    i_reg_rd <= 1'b1;
    @(posedge i_clock);
    i_reg_rd <= 1'b0;
    #1;
    chk({7'h00, o_reg_rvalid}, 8'h01, "rvalid next cycle");
    chk(o_reg_rdata, 8'h45, "ctrl next cycle");
  endtask : t_ctrl_rw

  task t_sense;
    reg_wr(8'h19, 8'hA7);
    chk(o_sense_scale, 8'hA7, "scale");
    reg_rd(8'h19, 8'hA7, "sense");
  endtask : t_sense

  task t_all_inputs;
    for (int s = 0; s < 8; s++) convert(s[2:0], 1'b0, 1'b0);
    convert(3'd3, 1'b1, 1'b0);
  endtask : t_all_inputs

  task t_read_only;
    reg_wr(8'h88, 8'hFF);
    reg_wr(8'h89, 8'hFF);
    reg_rd(8'h88, 8'hEB, "high");
    reg_rd(8'h89, 8'h04, "low");
    reg_rd(8'h20, 8'h00, "unmapped");
  endtask : t_read_only

  task t_restart;
    reg_wr(8'h87, 8'h82);
    reg_rd(8'h87, 8'h82, "ctrl busy");
    convert(3'd5, 1'b0, 1'b0);
  endtask : t_restart

  // reset in mid conversion clears outputs and registers
  task t_mid_reset;
    reg_wr(8'h87, 8'h84);
    @(posedge i_clock);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    #1;
    chk({5'h00, o_busy, o_core_power, o_core_start}, 8'h00, "reset outputs");
    reg_rd(8'h88, 8'h00, "high");
    reg_rd(8'h87, 8'h00, "ctrl");
    reg_rd(8'h19, 8'h00, "sense");
  endtask : t_mid_reset

  initial begin
    repeat (4) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    t_reset_values();
    t_ctrl_rw();
    t_sense();
    t_all_inputs();
    t_read_only();
    t_restart();
    t_mid_reset();
    convert(3'd6, 1'b0, 1'b1);
    conclude();
  end
endmodule : tb_top
